// [msc_meter_supervisor.sv]
// Supervisory sequencer: start-up, settings load, brownout save, energy sampling
`timescale 1ns/1ps
// What this block does
// - Initialise, then wait idle for interrupts
// - Leave idle only on interrupt, then return
// - Set up display, SPI, serial ports first
// - Low select means calibration, high means normal
// - Calibration mode tri-states all SPI outputs
// - Calibration mode shows its message on display
// - Normal mode clears registers, loads stored settings
// - After loading, enable timer, then go idle
// - Only brownout and timer interrupts are serviced
// - Brownout enabled through meter register 10H
// - Falling meter interrupt runs energy save
// - Energy save finishes in bounded short time
// - Timer interrupt at programmed period sets sampling
// - Sample read, scaled by coefficient, displayed
// - Creep filter on: small sample discarded
// - Samples below creep threshold stay out
// - Pages hold energy, settings, coefficient
module msc_meter_supervisor #(
	parameter int unsigned SAMPLE_PERIOD = msc_pkg::SAMPLE_PERIOD_CYC,
	parameter int unsigned SPI_HALF      = msc_pkg::SPI_HALF_CYC
) (
	input  wire logic                           CLK,
	input  wire logic                           SRST,
	input  wire logic                           CE,
	input  wire logic                           CALIBRATION_SELECT_N,
	input  wire logic                           EXTERNAL_INTERRUPT_INPUT_N,
	input  wire logic                           CREEP_EN,
	input  wire logic [msc_pkg::ENERGY_W-1:0]   CREEP_THRESHOLD,
	input  wire logic                           SPI_MISO,
	output logic                                SPI_SCLK,
	output logic                                SPI_SCLK_OE,
	output logic                                SPI_MOSI,
	output logic                                SPI_MOSI_OE,
	output logic                                CS_METER_N,
	output logic                                CS_METER_N_OE,
	output logic                                CS_EEPROM_N,
	output logic                                CS_EEPROM_N_OE,
	output logic [msc_pkg::TOTAL_W-1:0]         DISP_VALUE,
	output msc_pkg::msc_msg_t                   DISP_MSG,
	output logic                                DISP_WR,
	output logic                                MODE_CAL,
	output logic                                IDLE
);
	import msc_pkg::*;

	localparam logic [31:0] PERIOD_M1 = 32'(SAMPLE_PERIOD - 1);

	msc_spi_if spi_bus ();

	msc_state_t          state_ff, nxt_state;
	logic [4:0]          idx_ff;
	logic [3:0]          byte_ff;
	logic                wait_ff, req_ff, last_ff, sel_ff, oe_ff;
	logic [7:0]          tx_ff, data_ff;
	logic [TOTAL_W-1:0]  total_ff;
	logic [COEF_W-1:0]   coef_ff;
	logic [ENERGY_W-1:0] sample_ff;
	logic [31:0]         tmr_cnt_ff;
	logic                tmr_en_ff, bo_armed_ff, irq_prev_ff, bo_pend_ff, tm_pend_ff;
	logic                frame_st, issue, frame_end, is_last, brownout_evt, tmr_hit;
	logic                bo_clr, tm_clr, discard;
	logic [3:0]          cfg_sub;
	logic [PROD_W-1:0]   product;

	////////////////////////////////////////////////////////////////////////
	// Frame helpers: lengths, memory addresses and byte contents
	function automatic logic [3:0] frame_len(input msc_state_t st);
		case (st)
			ST_EE_RD:   frame_len = LEN_EE_RD;
			ST_MTR_WR:  frame_len = LEN_MTR_WR;
			ST_SV_WREN: frame_len = LEN_WREN;
			ST_SV_WR:   frame_len = LEN_SV_WR;
			ST_SMP_RD:  frame_len = LEN_SMP;
			default:    frame_len = 4'h0;
		endcase
	endfunction

	function automatic logic [7:0] ee_addr(input logic [4:0] idx);
		if (idx < IDX_CFG_FIRST)
			ee_addr = EE_PAGE1_BASE + {3'h0, idx};
		else if (idx < IDX_COEF_FIRST)
			ee_addr = EE_PAGE2_BASE + {3'h0, 5'(idx - IDX_CFG_FIRST)};
		else
			ee_addr = EE_PAGE3_BASE + {3'h0, 5'(idx - IDX_COEF_FIRST)};
	endfunction

	function automatic logic [7:0] frame_byte(input msc_state_t st, input logic [3:0] b,
			input logic [4:0] idx, input logic [3:0] sub, input logic [7:0] data,
			input logic [TOTAL_W-1:0] total);
		frame_byte = 8'h00;
		case (st)
			ST_EE_RD:   frame_byte = (b == 4'h0) ? EE_CMD_READ : (b == 4'h1) ? ee_addr(idx) : 8'h00;
			// interrupt enable lands at 10H with brownout bit set
			ST_MTR_WR:  if (sub == CFG_IRQEN_SUB)
					frame_byte = (b == 4'h0) ? (MTR_WR_FLAG | MTR_IRQ_EN_ADDR) : (data | MTR_BO_IRQ_MASK);
				else
					frame_byte = (b == 4'h0) ? (MTR_WR_FLAG | (MTR_CFG_BASE + {4'h0, sub})) : data;
			ST_SV_WREN: frame_byte = EE_CMD_WREN;
			ST_SV_WR:   if (b == 4'h0)
					frame_byte = EE_CMD_WRITE;
				else if (b == 4'h1)
					frame_byte = EE_PAGE1_BASE;
				else
					frame_byte = total[8*(int'(b) - int'(BYTE_DATA0)) +: 8];
			ST_SMP_RD:  frame_byte = (b == 4'h0) ? MTR_ENERGY_ADDR : 8'h00;
			default:    frame_byte = 8'h00;
		endcase
	endfunction

	assign cfg_sub   = 4'(idx_ff - IDX_CFG_FIRST);
	assign frame_st  = (frame_len(state_ff) != 4'h0);
	assign is_last   = (byte_ff == 4'(frame_len(state_ff) - 4'h1));
	assign issue     = frame_st && !wait_ff && !spi_bus.busy;
	assign frame_end = spi_bus.done && last_ff;
	assign product   = sample_ff * coef_ff;
	assign discard   = CREEP_EN && (sample_ff < CREEP_THRESHOLD);

	////////////////////////////////////////////////////////////////////////
	// Byte requests to the SPI engine; one outstanding byte at a time
	always_ff @(posedge CLK) begin
		if (SRST) begin
			req_ff  <= 1'h0;
			wait_ff <= 1'h0;
			tx_ff   <= '0;
			last_ff <= 1'h0;
			sel_ff  <= DEV_METER;
			byte_ff <= '0;
		end else if (CE) begin
			req_ff <= issue;
			if (issue) begin
				wait_ff <= 1'h1;
				tx_ff   <= frame_byte(state_ff, byte_ff, idx_ff, cfg_sub, data_ff, total_ff);
				last_ff <= is_last;
				sel_ff  <= (state_ff == ST_MTR_WR || state_ff == ST_SMP_RD) ? DEV_METER : DEV_EE;
			end else if (spi_bus.done) begin
				wait_ff <= 1'h0;
				byte_ff <= last_ff ? 4'h0 : byte_ff + 4'h1;
			end
		end
	end

	assign spi_bus.req  = req_ff;
	assign spi_bus.tx   = tx_ff;
	assign spi_bus.last = last_ff;
	assign spi_bus.sel  = sel_ff;

	msc_spi_engine #(.HALF(SPI_HALF)) u_spi (
		.clk        (CLK),
		.srst       (SRST),
		.ce         (CE),
		.bus        (spi_bus.engine),
		.miso       (SPI_MISO),
		.sclk       (SPI_SCLK),
		.mosi       (SPI_MOSI),
		.cs_meter_n (CS_METER_N),
		.cs_ee_n    (CS_EEPROM_N)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_INIT:    nxt_state = ST_PORTS;
			ST_PORTS:   nxt_state = ST_MODE;
			ST_MODE:    nxt_state = CALIBRATION_SELECT_N ? ST_CLEAR : ST_CAL;
			ST_CAL:     nxt_state = ST_CAL;
			ST_CLEAR:   nxt_state = ST_EE_RD;
			ST_EE_RD:   if (frame_end) begin
					if (idx_ff >= IDX_CFG_FIRST && idx_ff < IDX_COEF_FIRST && cfg_sub != CFG_NA_SUB)
						nxt_state = ST_MTR_WR;
					else if (idx_ff == IDX_LAST)
						nxt_state = ST_TMR_EN;
				end
			ST_MTR_WR:  if (frame_end) nxt_state = ST_EE_RD;
			ST_TMR_EN:  nxt_state = ST_IDLE;
			// leave idle only for a pending interrupt
			ST_IDLE:    if (bo_pend_ff) nxt_state = ST_SV_WREN;
				else if (tm_pend_ff) nxt_state = ST_SMP_RD;
			// save is two short frames with no busy polling
			ST_SV_WREN: if (frame_end) nxt_state = ST_SV_WR;
			ST_SV_WR:   if (frame_end) nxt_state = ST_IDLE;
			ST_SMP_RD:  if (frame_end) nxt_state = ST_SMP_ADD;
			ST_SMP_ADD: nxt_state = ST_IDLE;
			default:    nxt_state = ST_INIT;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_ff <= ST_INIT;
			idx_ff   <= '0;
		end else if (CE) begin
			state_ff <= nxt_state;
			if (state_ff == ST_CLEAR)
				idx_ff <= '0;
			else if (frame_end && (state_ff == ST_MTR_WR ||
					(state_ff == ST_EE_RD && nxt_state != ST_MTR_WR)))
				idx_ff <= idx_ff + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode, pin drive and status; the display bus keeps driving in calibration
	always_ff @(posedge CLK) begin
		if (SRST) begin
			oe_ff    <= 1'h0;
			MODE_CAL <= 1'h0;
			IDLE     <= 1'h0;
		end else if (CE) begin
			// SPI pins taken in port setup
			if (state_ff == ST_PORTS)
				oe_ff <= 1'h1;
			// release the bus to the calibrator
			else if (nxt_state == ST_CAL)
				oe_ff <= 1'h0;
			MODE_CAL <= (nxt_state == ST_CAL);
			// idle flag mirrors the wait state
			IDLE <= (nxt_state == ST_IDLE);
		end
	end

	assign SPI_SCLK_OE    = oe_ff;
	assign SPI_MOSI_OE    = oe_ff;
	assign CS_METER_N_OE  = oe_ff;
	assign CS_EEPROM_N_OE = oe_ff;

	////////////////////////////////////////////////////////////////////////
	// Interrupt sources; a new event wins over the clear in the same cycle
	assign brownout_evt = bo_armed_ff && irq_prev_ff && !EXTERNAL_INTERRUPT_INPUT_N;
	assign tmr_hit      = tmr_en_ff && (tmr_cnt_ff == PERIOD_M1);
	assign bo_clr       = (state_ff == ST_IDLE) && bo_pend_ff;
	// timer waits while a brownout is pending
	assign tm_clr       = (state_ff == ST_IDLE) && tm_pend_ff && !bo_pend_ff;

	// brownout line and internal timer only
	always_ff @(posedge CLK) begin
		if (SRST) begin
			irq_prev_ff <= 1'h1;
			bo_pend_ff  <= 1'h0;
			tm_pend_ff  <= 1'h0;
			bo_armed_ff <= 1'h0;
			tmr_en_ff   <= 1'h0;
			tmr_cnt_ff  <= '0;
		end else if (CE) begin
			irq_prev_ff <= EXTERNAL_INTERRUPT_INPUT_N;
			// falling edge requests the energy save
			bo_pend_ff  <= brownout_evt || (bo_pend_ff && !bo_clr);
			tm_pend_ff  <= tmr_hit || (tm_pend_ff && !tm_clr);
			// armed once 10H has been written
			if (state_ff == ST_MTR_WR && frame_end && cfg_sub == CFG_IRQEN_SUB)
				bo_armed_ff <= 1'h1;
			if (state_ff == ST_TMR_EN)
				tmr_en_ff <= 1'h1;
			if (tmr_en_ff)
				tmr_cnt_ff <= tmr_hit ? '0 : tmr_cnt_ff + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Working registers; energy total is kept in scaled units
	always_ff @(posedge CLK) begin
		if (SRST) begin
			total_ff  <= '0;
			coef_ff   <= '0;
			sample_ff <= '0;
			data_ff   <= '0;
		end else if (CE) begin
			if (state_ff == ST_INIT || state_ff == ST_CLEAR) begin
				total_ff  <= '0;
				coef_ff   <= '0;
				sample_ff <= '0;
				data_ff   <= '0;
			end else if (state_ff == ST_EE_RD && frame_end) begin
				if (idx_ff < IDX_CFG_FIRST)
					total_ff[8*idx_ff +: 8] <= spi_bus.rx;
				else if (idx_ff < IDX_COEF_FIRST)
					data_ff <= spi_bus.rx;
				else
					coef_ff[8*(idx_ff - IDX_COEF_FIRST) +: 8] <= spi_bus.rx;
			end else if (state_ff == ST_SMP_RD && spi_bus.done && byte_ff != 4'h0) begin
				// energy arrives most significant byte first
				sample_ff <= {sample_ff[ENERGY_W-9:0], spi_bus.rx};
			end else if (state_ff == ST_SMP_ADD && !discard) begin
				// with the creep filter on, only samples at or above the threshold count
				total_ff <= total_ff + {{(TOTAL_W-PROD_W){1'h0}}, product};
			end
		end
	end

	// Display follows the total after each sample, or the calibration message
	always_ff @(posedge CLK) begin
		if (SRST) begin
			DISP_VALUE <= '0;
			DISP_MSG   <= MSG_NONE;
			DISP_WR    <= 1'h0;
		end else if (CE) begin
			DISP_WR <= 1'h0;
			if (state_ff == ST_MODE && nxt_state == ST_CAL) begin
				DISP_MSG <= MSG_CAL;
				DISP_WR  <= 1'h1;
			end else if (state_ff == ST_SMP_ADD) begin
				DISP_VALUE <= discard ? total_ff : total_ff + {{(TOTAL_W-PROD_W){1'h0}}, product};
				DISP_MSG   <= MSG_ENERGY;
				DISP_WR    <= 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	localparam int SAVE_MAX = 14 * (16 * SPI_HALF + 6) + 8;
	logic [15:0] save_cnt_ff;
	always_ff @(posedge CLK) begin
		if (SRST || state_ff == ST_IDLE)
			save_cnt_ff <= '0;
		else if (CE && (state_ff == ST_SV_WREN || state_ff == ST_SV_WR))
			save_cnt_ff <= save_cnt_ff + 16'h1;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	AST_CAL_TRISTATE: assert property (MODE_CAL |-> !SPI_SCLK_OE && !CS_EEPROM_N_OE)
		else $error("SPI driven in calibration mode");
	AST_CAL_MSG: assert property (MODE_CAL |-> DISP_MSG == MSG_CAL)
		else $error("calibration message missing");
	AST_MODE_SELECT: assert property (state_ff == ST_MODE && CE |=> MODE_CAL == !$past(CALIBRATION_SELECT_N))
		else $error("wrong mode chosen");
	AST_PORTS_FIRST: assert property (state_ff == ST_MODE |-> oe_ff)
		else $error("mode decided before port setup");
	AST_IDLE_HOLD: assert property (IDLE && !bo_pend_ff && !tm_pend_ff && CE |=> IDLE)
		else $error("idle left without interrupt");
	AST_BO_FIRST: assert property (state_ff == ST_IDLE && bo_pend_ff && tm_pend_ff && CE
		|=> state_ff == ST_SV_WREN && tm_pend_ff)
		else $error("timer served before brownout");
	AST_BO_CATCH: assert property (brownout_evt && CE |=> bo_pend_ff)
		else $error("brownout edge lost");
	AST_IRQEN_ADDR: assert property (req_ff && state_ff == ST_MTR_WR && byte_ff == 4'h0
		&& cfg_sub == CFG_IRQEN_SUB |-> tx_ff == (MTR_WR_FLAG | MTR_IRQ_EN_ADDR))
		else $error("interrupt enable sent to wrong address");
	AST_SAVE_BOUND: assert property (save_cnt_ff <= 16'(SAVE_MAX))
		else $error("energy save too long");
	AST_CREEP_HOLD: assert property (state_ff == ST_SMP_ADD && CE && discard |=> $stable(total_ff))
		else $error("creep sample added");
	AST_SCALE_ADD: assert property (state_ff == ST_SMP_ADD && CE && !discard
		|=> total_ff == $past(total_ff) + {{(TOTAL_W-PROD_W){1'h0}}, $past(product)})
		else $error("sample not scaled into total");
	AST_TIMER_PEND: assert property (tmr_hit && CE |=> tm_pend_ff)
		else $error("timer match lost");

	COV_CAL: cover property (state_ff == ST_MODE ##1 MODE_CAL);
	COV_SAVE: cover property (state_ff == ST_SV_WR ##1 state_ff == ST_IDLE);
	COV_SAMPLE: cover property (state_ff == ST_SMP_ADD && !discard);
	COV_CREEP: cover property (state_ff == ST_SMP_ADD && discard);
endmodule

// [msc_pkg.sv]
// Shared constants, encodings and types of the meter supervisory controller
package msc_pkg;
	// Data widths
	localparam int unsigned ENERGY_W = 24;
	localparam int unsigned COEF_W   = 24;
	localparam int unsigned PROD_W   = ENERGY_W + COEF_W;
	localparam int unsigned TOTAL_W  = 88;
	// Serial memory commands
	localparam logic [7:0] EE_CMD_READ  = 8'h03;
	localparam logic [7:0] EE_CMD_WRITE = 8'h02;
	localparam logic [7:0] EE_CMD_WREN  = 8'h06;
	// Memory pages: energy, metering settings, coefficient
	localparam logic [7:0] EE_PAGE1_BASE = 8'h00;
	localparam logic [7:0] EE_PAGE2_BASE = 8'h10;
	localparam logic [7:0] EE_PAGE3_BASE = 8'h20;
	// Metering device register map
	localparam logic [7:0] MTR_WR_FLAG     = 8'h80;
	localparam logic [7:0] MTR_IRQ_EN_ADDR = 8'h10;
	localparam logic [7:0] MTR_ENERGY_ADDR = 8'h02;
	localparam logic [7:0] MTR_CFG_BASE    = 8'h00;
	localparam logic [7:0] MTR_BO_IRQ_MASK = 8'h10;
	// Load walk indexes over the three pages
	localparam logic [4:0] IDX_CFG_FIRST  = 5'h0B;
	localparam logic [4:0] IDX_COEF_FIRST = 5'h1B;
	localparam logic [4:0] IDX_LAST       = 5'h1D;
	localparam logic [3:0] CFG_NA_SUB     = 4'h4;
	localparam logic [3:0] CFG_IRQEN_SUB  = 4'hB;
	// Frame lengths in bytes
	localparam logic [3:0] LEN_EE_RD  = 4'h3;
	localparam logic [3:0] LEN_MTR_WR = 4'h2;
	localparam logic [3:0] LEN_WREN   = 4'h1;
	localparam logic [3:0] LEN_SV_WR  = 4'hD;
	localparam logic [3:0] LEN_SMP    = 4'h4;
	localparam logic [3:0] BYTE_DATA0 = 4'h2;
	// SPI timing
	localparam int unsigned SPI_HALF_CYC = 4;
	localparam logic DEV_METER = 1'h0;
	localparam logic DEV_EE    = 1'h1;
	// Default sample period in cycles (1 s at 250 MHz)
	localparam int unsigned SAMPLE_PERIOD_CYC = 250000000;

	typedef enum logic [3:0] {
		ST_INIT    = 4'h0,
		ST_PORTS   = 4'h1,
		ST_MODE    = 4'h2,
		ST_CAL     = 4'h3,
		ST_CLEAR   = 4'h4,
		ST_EE_RD   = 4'h5,
		ST_MTR_WR  = 4'h6,
		ST_TMR_EN  = 4'h7,
		ST_IDLE    = 4'h8,
		ST_SV_WREN = 4'h9,
		ST_SV_WR   = 4'hA,
		ST_SMP_RD  = 4'hB,
		ST_SMP_ADD = 4'hC
	} msc_state_t;

	typedef enum logic [1:0] {
		MSG_NONE   = 2'h0,
		MSG_CAL    = 2'h1,
		MSG_ENERGY = 2'h2
	} msc_msg_t;
endpackage

// [msc_spi_if.sv]
// Byte request channel between the sequencer and the SPI engine
`timescale 1ns/1ps
interface msc_spi_if;
	logic       req;
	logic [7:0] tx;
	logic       last;
	logic       sel;
	logic       busy;
	logic       done;
	logic [7:0] rx;
	modport ctrl   (output req, tx, last, sel, input busy, done, rx);
	modport engine (input req, tx, last, sel, output busy, done, rx);
endinterface

// [msc_spi_engine.sv]
// SPI mode-0 byte engine with chip select held across a frame
`timescale 1ns/1ps
module msc_spi_engine #(
	parameter int unsigned HALF = msc_pkg::SPI_HALF_CYC
) (
	input  wire logic    clk,
	input  wire logic    srst,
	input  wire logic    ce,
	msc_spi_if.engine    bus,
	input  wire logic    miso,
	output logic         sclk,
	output logic         mosi,
	output logic         cs_meter_n,
	output logic         cs_ee_n
);
	import msc_pkg::*;

	localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
	localparam logic [2:0] BIT_LAST = 3'h7;

	logic [7:0] hc_ff;
	logic [2:0] bit_ff;
	logic       phase_ff;
	logic       active_ff;
	logic       last_ff;
	logic       done_ff;
	logic [7:0] sh_ff;

	assign bus.busy = active_ff;
	assign bus.done = done_ff;
	assign bus.rx   = sh_ff;

	////////////////////////////////////////////////////////////////////////
	// Shifter: MISO sampled on the rising edge, MOSI changes on the falling
	always_ff @(posedge clk) begin
		if (srst) begin
			hc_ff      <= '0;
			bit_ff     <= '0;
			phase_ff   <= 1'h0;
			active_ff  <= 1'h0;
			last_ff    <= 1'h0;
			done_ff    <= 1'h0;
			sh_ff      <= '0;
			sclk       <= 1'h0;
			mosi       <= 1'h0;
			cs_meter_n <= 1'h1;
			cs_ee_n    <= 1'h1;
		end else if (ce) begin
			done_ff <= 1'h0;
			if (!active_ff) begin
				if (bus.req) begin
					active_ff  <= 1'h1;
					sh_ff      <= bus.tx;
					mosi       <= bus.tx[7];
					last_ff    <= bus.last;
					hc_ff      <= '0;
					bit_ff     <= '0;
					phase_ff   <= 1'h0;
					cs_meter_n <= (bus.sel != DEV_METER);
					cs_ee_n    <= (bus.sel != DEV_EE);
				end
			end else if (hc_ff == HALF_M1) begin
				hc_ff <= '0;
				if (!phase_ff) begin
					sclk     <= 1'h1;
					sh_ff    <= {sh_ff[6:0], miso};
					phase_ff <= 1'h1;
				end else begin
					sclk     <= 1'h0;
					phase_ff <= 1'h0;
					mosi     <= sh_ff[7];
					if (bit_ff == BIT_LAST) begin
						active_ff <= 1'h0;
						done_ff   <= 1'h1;
						// Select released only after the last byte of a frame
						if (last_ff) begin
							cs_meter_n <= 1'h1;
							cs_ee_n    <= 1'h1;
						end
					end else begin
						bit_ff <= bit_ff + 3'h1;
					end
				end
			end else begin
				hc_ff <= hc_ff + 8'h01;
			end
		end
	end
endmodule

// [msc_spi_partner.sv]
// Behavioural meter and serial memory on the far side of the SPI link
`timescale 1ns/1ps
module msc_spi_partner (
	input  wire logic        clk,
	input  wire logic        sclk,
	input  wire logic        mosi,
	input  wire logic        cs_meter_n,
	input  wire logic        cs_ee_n,
	input  wire logic [23:0] energy,
	output logic             miso,
	output logic [7:0]       irq_en,
	output logic [87:0]      saved,
	output int               n_save
);
	logic [7:0] sh;
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] nxt_out;
	int         nb;
	int         bits;
	initial begin
		miso = 1'b0;
		irq_en = 8'h00;
		saved = '0;
		n_save = 0;
	end
	////////////////////////////////////////////////////////////////////////////
	// pages as the calibrator left them
	function automatic logic [7:0] mem(input logic [7:0] a);
		if (a < 8'h0B)
			return saved[8*a +: 8];
		if (a == 8'h20)
			return 8'h03;
		return (a[7:4] == 4'h1) ? ~a : 8'h00;
	endfunction
	// Byte shown in slot k; energy goes out MSB first
	function automatic logic [7:0] reply(input int k);
		if (!cs_ee_n)
			return (k == 2) ? mem(b1) : 8'hA5;
		if (b0 == 8'h02 && k > 0 && k < 4)
			return energy[8*(3-k) +: 8];
		return 8'hA5;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// A select falling starts a fresh frame
	always @(negedge cs_meter_n or negedge cs_ee_n) begin
		nb = 0;
		bits = 0;
	end
	// Shift in on the rise, act on each whole byte
	always @(posedge sclk) begin
		sh = {sh[6:0], mosi};
		bits++;
		if (bits == 8) begin
			bits = 0;
			if (nb == 0)
				b0 = sh;
			if (nb == 1)
				b1 = sh;
			if (!cs_meter_n && nb == 1 && b0 == 8'h90)
				irq_en = sh;
			if (!cs_ee_n && b0 == 8'h02 && nb >= 2 && nb <= 12)
				saved[8*(nb-2) +: 8] = sh;
			if (!cs_ee_n && b0 == 8'h02 && nb == 12)
				n_save++;
			nb++;
		end
	end
	// Data moves on the fall so it is settled at the next rise
	always @(negedge sclk) begin
		nxt_out = reply(nb);
		if (!(cs_meter_n && cs_ee_n))
			miso = nxt_out[7-bits];
	end
	// Released line wanders so a stale bit is never taken as data
	always @(posedge clk) begin
		if (cs_meter_n && cs_ee_n)
			miso = ~miso;
	end
endmodule

// [tb.sv]
// Self-checking bench for the meter supervisory controller
`timescale 1ns/1ps
module tb;
	import msc_pkg::*;
	localparam int unsigned PERIOD = 2000;
	localparam int unsigned HALF   = 1;
	localparam int unsigned BO_MAX = 14 * (16 * HALF + 6) + 8;
	logic          clk       = 1'b0;
	logic          srst      = 1'b1;
	logic          ce        = 1'b1;
	logic          cal_sel_n = 1'b1;
	logic          ext_irq_n = 1'b1;
	logic          creep_en  = 1'b0;
	logic [23:0]   creep_thr = 24'h0;
	logic [23:0]   energy    = 24'h0;
	logic          miso;
	logic          sclk, sclk_oe, mosi, mosi_oe, csm_n, csm_oe, cse_n, cse_oe;
	logic [87:0]   disp_value;
	msc_msg_t      disp_msg;
	logic          disp_wr, mode_cal, idle;
	logic [7:0]    irq_en;
	logic [87:0]   saved;
	int            n_save;
	int            n_errors  = 0;
	int            compares  = 0;
	int            cycles    = 0;
	longint        last_wr   = 0;
	// Released selects float high through pull-ups
	wire sclk_w = sclk_oe ? sclk : 1'b0;
	wire mosi_w = mosi_oe ? mosi : 1'b0;
	wire csm_w  = csm_oe ? csm_n : 1'b1;
	wire cse_w  = cse_oe ? cse_n : 1'b1;
	msc_meter_supervisor #(.SAMPLE_PERIOD(PERIOD), .SPI_HALF(HALF)) msc_meter_supervisor_inst (
		.CLK(clk), .SRST(srst), .CE(ce), .CALIBRATION_SELECT_N(cal_sel_n),
		.EXTERNAL_INTERRUPT_INPUT_N(ext_irq_n), .CREEP_EN(creep_en),
		.CREEP_THRESHOLD(creep_thr), .SPI_MISO(miso), .SPI_SCLK(sclk),
		.SPI_SCLK_OE(sclk_oe), .SPI_MOSI(mosi), .SPI_MOSI_OE(mosi_oe),
		.CS_METER_N(csm_n), .CS_METER_N_OE(csm_oe), .CS_EEPROM_N(cse_n),
		.CS_EEPROM_N_OE(cse_oe), .DISP_VALUE(disp_value), .DISP_MSG(disp_msg),
		.DISP_WR(disp_wr), .MODE_CAL(mode_cal), .IDLE(idle));
	msc_spi_partner msc_spi_partner_inst (
		.clk(clk), .sclk(sclk_w), .mosi(mosi_w), .cs_meter_n(csm_w), .cs_ee_n(cse_w),
		.energy(energy), .miso(miso), .irq_en(irq_en), .saved(saved), .n_save(n_save));
	////////////////////////////////////////////////////////////////////////////
	// 250 MHz clock and a hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [87:0] seen, input logic [87:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// Bounded wait: 0 idle, 1 display pulse, 2 calibration
	task automatic wait_for(input int which, input int lim);
		logic hit;
		int   n;
		hit = 1'b0;
		n = 0;
		while (hit !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
			hit = (which == 0) ? idle : (which == 1) ? disp_wr : mode_cal;
		end
		check(hit, 1'b1);
	endtask
	task automatic do_reset(input logic sel_n);
		@(negedge clk);
		srst = 1'b1;
		cal_sel_n = sel_n;
		last_wr = 0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Cable grounds the select: pins released, message shown
	task automatic t_cal();
		do_reset(1'b0);
		wait_for(2, 20);
		check({sclk_oe, mosi_oe, csm_oe, cse_oe}, 4'h0);
		check({disp_wr, disp_msg}, {1'b1, MSG_CAL});
		check(idle, 1'b0);
		@(negedge clk);
		check({disp_wr, mode_cal}, 2'h1);
	endtask
	// Pull-up selects normal start, load then idle; CE low holds start-up.
	// Display stays cleared; a restored total shows only at the next sample
	task automatic t_normal();
		do_reset(1'b1);
		ce = 1'b0;
		repeat (8) @(negedge clk);
		check({sclk_oe, idle}, 2'h0);
		ce = 1'b1;
		wait_for(0, 6000);
		check({sclk_oe, mosi_oe, csm_oe, cse_oe}, 4'hF);
		check(irq_en, 8'hF4);
		check(mode_cal, 1'b0);
		check({disp_msg, disp_value}, {MSG_NONE, 88'h0});
	endtask
	// One timer sample with the given creep setting
	task automatic t_sample(input logic [23:0] e, input logic c, input logic [23:0] thr,
			input logic [87:0] exp);
		energy = e;
		creep_en = c;
		creep_thr = thr;
		wait_for(1, 2 * PERIOD);
		if (last_wr != 0)
			check(($time - last_wr) / 4, PERIOD);
		last_wr = $time;
		check({disp_msg, disp_value}, {MSG_ENERGY, exp});
		wait_for(0, 200);
	endtask
	// Line drop timed so the timer match falls inside the save; a second
	// drop during that save leaves both requests pending at idle
	task automatic t_brown(input logic [87:0] exp, input logic [87:0] exp_smp);
		int n0;
		int n;
		n0 = n_save;
		n = 0;
		repeat (PERIOD - 230) @(negedge clk);
		ext_irq_n = 1'b0;
		while (n_save == n0 && n < BO_MAX) begin
			@(negedge clk);
			n++;
			ext_irq_n = (n == 4);
		end
		check(n_save, n0 + 1);
		n = 0;
		while (n_save == n0 + 1 && n < BO_MAX) begin
			@(negedge clk);
			n++;
		end
		check(n_save, n0 + 2);
		check(saved, exp);
		wait_for(1, 200);
		check({disp_msg, disp_value}, {MSG_ENERGY, exp_smp});
		wait_for(0, 50);
		ext_irq_n = 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		t_cal();
		t_normal();
		t_sample(24'h64, 1'b0, 24'h0, 88'h12C);
		t_sample(24'h28, 1'b1, 24'h32, 88'h12C);
		t_sample(24'h32, 1'b1, 24'h32, 88'h1C2);
		t_brown(88'h1C2, 88'h258);
		t_normal();
		t_sample(24'h0A, 1'b0, 24'h0, 88'h1E0);
		complete_run();
	end
endmodule
